// ==== rtl/isp_pkg.sv ====
package isp_pkg;
    // ==========================================
    // Clock and serial timing
    localparam int  SYS_CLK_HZ      = 10_000_000;
    localparam int  SCK_MIN_CPU_CYC = 2;
    localparam int  SCK_HALF_CYC    = 4;
    localparam int  RST_PULSE_CYC   = 4;
    localparam int  INSTR_BITS      = 32;

    // ==========================================
    // Wait times
    localparam real ENABLE_WAIT_MS     = 20.0;
    localparam real FLASH_PAGE_WAIT_MS = 4.5;
    localparam real EEPROM_BYTE_WAIT_MS = 3.6;
    localparam real CHIP_ERASE_WAIT_MS = 9.0;
    localparam int  ENABLE_WAIT_CYC =
        int'($ceil(ENABLE_WAIT_MS * SYS_CLK_HZ / 1000.0));
    localparam int  FLASH_PAGE_WAIT_CYC =
        int'($ceil(FLASH_PAGE_WAIT_MS * SYS_CLK_HZ / 1000.0));
    localparam int  EEPROM_BYTE_WAIT_CYC =
        int'($ceil(EEPROM_BYTE_WAIT_MS * SYS_CLK_HZ / 1000.0));
    localparam int  CHIP_ERASE_WAIT_CYC =
        int'($ceil(CHIP_ERASE_WAIT_MS * SYS_CLK_HZ / 1000.0));

    // ==========================================
    // Instruction bytes
    localparam logic [7:0] OP_ENABLE  = 8'hAC;
    localparam logic [7:0] OP_ECHO    = 8'h53;
    localparam logic [7:0] OP_ERASE   = 8'h80;
    localparam logic [7:0] OP_POLL    = 8'hF0;
    localparam logic [7:0] OP_LD_EXT  = 8'h4D;
    localparam logic [7:0] OP_LD_HI   = 8'h48;
    localparam logic [7:0] OP_LD_LO   = 8'h40;
    localparam logic [7:0] OP_WR_PAGE = 8'h4C;
    localparam logic [7:0] OP_RD_HI   = 8'h28;
    localparam logic [7:0] OP_RD_LO   = 8'h20;
    localparam logic [7:0] OP_RD_EE   = 8'hA0;
    localparam logic [7:0] OP_WR_EE   = 8'hC0;
    localparam logic [7:0] OP_WR_EEPG = 8'hC2;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [31:0] ENABLE_WORD = {OP_ENABLE, OP_ECHO, 16'h0000};
    localparam logic [31:0] POLL_WORD   = {OP_POLL, 24'h00_0000};
endpackage

// ==== rtl/isp_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface isp_if;
    logic sck;
    logic mosi;
    logic miso;
    logic rst_n;
    modport prog (output sck, output mosi, output rst_n, input miso);
    modport dev  (input sck, input mosi, input rst_n, output miso);
endinterface
`default_nettype wire

// ==== rtl/isp_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module isp_fifo #(
    parameter int W     = 32,
    parameter int DEPTH = 16
) (
    input  wire logic         clk_i,       // System clock
    input  wire logic         rst_i,       // Async reset, high
    input  wire logic [W-1:0] in_data_i,   // Word in
    input  wire logic         in_valid_i,  // Word offered
    output logic              in_ready_o,  // Room left
    output logic [W-1:0]      out_data_o,  // Head word
    output logic              out_valid_o, // Not empty
    input  wire logic         out_ready_i  // Head taken
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
        logic                    rdy;
    } isp_fifo_st_t;

    isp_fifo_st_t s;
    isp_fifo_st_t n;
    logic         push;
    logic         pop;

    assign out_data_o  = s.mem[s.rp];
    assign out_valid_o = s.cnt != '0;
    assign in_ready_o  = s.rdy;

    always_comb begin
        n    = s;
        push = in_valid_i && s.rdy;
        pop  = out_ready_i && (s.cnt != '0);
        if (push) begin
            n.mem[s.wp] = in_data_i;
            n.wp        = s.wp + 1'b1;
        end
        if (pop) begin
            n.rp = s.rp + 1'b1;
        end
        n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
        n.rdy = n.cnt != (AW+1)'(DEPTH);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s     <= '0;
            s.rdy <= 1'b1;
        end else begin
            s <= n;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/isp_dev.sv ====
`timescale 1ns/1ps
`default_nettype none
module isp_dev
    import isp_pkg::*;
#(
    parameter int FLASH_WORDS    = 512,
    parameter int PAGE_WORDS     = 128,
    parameter int EE_BYTES       = 256,
    parameter int FLASH_WAIT_CYC = isp_pkg::FLASH_PAGE_WAIT_CYC,
    parameter int EE_WAIT_CYC    = isp_pkg::EEPROM_BYTE_WAIT_CYC,
    parameter int ERASE_WAIT_CYC = isp_pkg::CHIP_ERASE_WAIT_CYC
) (
    input  wire logic CLK_I,       // Device clock
    input  wire logic RST_I,       // Async reset, high
    isp_if.dev        LINK,        // Serial programming pins
    output logic      PROG_MODE_O, // Programming enabled
    output logic      BUSY_O       // Self-timed write running
);
    import isp_pkg::*;

    localparam int FAW = $clog2(FLASH_WORDS);
    localparam int PAW = $clog2(PAGE_WORDS);
    localparam int EAW = $clog2(EE_BYTES);
    localparam int BW  = $clog2(ERASE_WAIT_CYC + 1);

    typedef struct packed {
        logic [1:0]                    sck_s;
        logic [1:0]                    mosi_s;
        logic [1:0]                    rst_s;
        logic                          sck_d;
        logic [4:0]                    bits;
        logic [31:0]                   rx;
        logic [7:0]                    tx;
        logic                          miso;
        logic                          enabled;
        logic [BW-1:0]                 busy_cnt;
        logic                          busy;
        logic [7:0]                    ext;
        logic [PAGE_WORDS-1:0][15:0]   pbuf;
        logic [FLASH_WORDS-1:0][15:0]  flash;
        logic [EE_BYTES-1:0][7:0]      ee;
    } isp_dev_st_t;

    isp_dev_st_t s;
    isp_dev_st_t n;

    assign LINK.miso   = s.miso;
    assign PROG_MODE_O = s.enabled;
    assign BUSY_O      = s.busy;

    always_comb begin
        logic          rise;
        logic          fall;
        logic [31:0]   w;
        logic [FAW-1:0] fa;
        logic [EAW-1:0] ea;
        logic [15:0]   fw;
        rise = 1'b0;
        fall = 1'b0;
        w    = '0;
        fa   = '0;
        ea   = '0;
        fw   = '0;
        n    = s;
        // ==========================================
        // Pin synchronisers and edge detect
        n.sck_s  = {s.sck_s[0], LINK.sck};
        n.mosi_s = {s.mosi_s[0], LINK.mosi};
        n.rst_s  = {s.rst_s[0], LINK.rst_n};
        n.sck_d  = s.sck_s[1];
        rise     = s.sck_s[1] && !s.sck_d;
        fall     = !s.sck_s[1] && s.sck_d;
        if (s.busy_cnt != '0) begin
            n.busy_cnt = s.busy_cnt - 1'b1;
        end
        if (s.rst_s[1]) begin
            // Port idle while reset pin high
            n.bits    = '0;
            n.enabled = 1'b0;
            n.tx      = '0;
            n.miso    = 1'b0;
        end else begin
            if (rise) begin
                n.rx   = {s.rx[30:0], s.mosi_s[1]};
                n.bits = s.bits + 1'b1;
                w      = n.rx;
                if (s.bits == 5'd7 || s.bits == 5'd15) begin
                    n.tx = w[7:0];
                end else if (s.bits[4:3] == 2'd2 && s.bits[2:0] == 3'd7)
                begin
                    // Third byte done: stage reply for fourth
                    fa   = FAW'({s.ext, w[15:0]});
                    ea   = EAW'(w[9:0]);
                    fw   = s.flash[fa];
                    n.tx = w[7:0];
                    if (w[23:16] == OP_POLL) begin
                        n.tx = {7'h00, s.busy};
                    end else if (s.enabled && w[23:16] == OP_RD_LO) begin
                        n.tx = fw[7:0];
                    end else if (s.enabled && w[23:16] == OP_RD_HI) begin
                        n.tx = fw[15:8];
                    end else if (s.enabled && w[23:16] == OP_RD_EE) begin
                        n.tx = s.ee[ea];
                    end
                end else if (s.bits == 5'd31) begin
                    // Whole instruction in
                    fa = FAW'({s.ext, w[23:8]});
                    ea = EAW'(w[17:8]);
                    if (w[31:24] == OP_ENABLE && w[23:16] == OP_ECHO) begin
                        n.enabled = 1'b1;
                    end else if (!s.enabled || s.busy) begin
                        n.enabled = s.enabled;
                    end else if (w[31:24] == OP_ENABLE
                                 && w[23:16] == OP_ERASE) begin
                        n.flash    = '1;
                        n.ee       = '1;
                        n.pbuf     = '1;
                        n.busy_cnt = BW'(ERASE_WAIT_CYC);
                    end else if (w[31:24] == OP_LD_EXT) begin
                        n.ext = w[15:8];
                    end else if (w[31:24] == OP_LD_LO) begin
                        n.pbuf[PAW'(w[14:8])][7:0] = w[7:0];
                    end else if (w[31:24] == OP_LD_HI) begin
                        n.pbuf[PAW'(w[14:8])][15:8] = w[7:0];
                    end else if (w[31:24] == OP_WR_PAGE) begin
                        for (int i = 0; i < PAGE_WORDS; i++) begin
                            n.flash[{fa[FAW-1:PAW], PAW'(i)}] =
                                s.pbuf[i];
                        end
                        n.pbuf     = '1;
                        n.busy_cnt = BW'(FLASH_WAIT_CYC);
                    end else if (w[31:24] == OP_WR_EE) begin
                        // Overwrite includes the erase step
                        n.ee[ea]   = w[7:0];
                        n.busy_cnt = BW'(EE_WAIT_CYC);
                    end
                end
            end
            if (fall) begin
                n.miso = s.tx[7];
                n.tx   = {s.tx[6:0], 1'b0};
            end
        end
        n.busy = n.busy_cnt != '0;
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            s       <= '0;
            s.rst_s <= 2'b11;
            s.pbuf  <= '1;
            s.flash <= '1;
            s.ee    <= '1;
        end else begin
            s <= n;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/isp_prog.sv ====
`timescale 1ns/1ps
`default_nettype none
module isp_prog
    import isp_pkg::*;
#(
    parameter int FIFO_DEPTH   = 16,
    parameter int ENABLE_WAIT  = isp_pkg::ENABLE_WAIT_CYC
) (
    input  wire logic        CLK_I,        // System clock
    input  wire logic        RST_I,        // Async reset, high
    isp_if.prog              LINK,         // Serial programming pins
    input  wire logic        SESSION_I,    // Hold device in programming
    input  wire logic [31:0] CMD_DATA_I,   // Instruction word
    input  wire logic        CMD_VALID_I,  // Instruction offered
    output logic             CMD_READY_O,  // Queue has room
    output logic [7:0]       RESP_DATA_O,  // Fourth byte returned
    output logic             RESP_VALID_O, // Reply pulse
    output logic             SYNC_O        // Enable echo seen
);
    import isp_pkg::*;

    localparam int CW = $clog2(ENABLE_WAIT + 1);

    typedef enum logic [2:0] {
        P_OFF, P_PULSE, P_WAIT, P_IDLE, P_SHIFT, P_CHECK
    } isp_pstate_t;

    typedef enum logic [1:0] {
        K_ENABLE, K_USER, K_POLL
    } isp_kind_t;

    typedef struct packed {
        isp_pstate_t state;
        isp_kind_t   kind;
        logic [CW-1:0] cnt;
        logic [4:0]  bits;
        logic [2:0]  ph;
        logic [31:0] tx;
        logic [31:0] rx;
        logic        wr;
        logic        sck;
        logic        mosi;
        logic        rst_n;
        logic [1:0]  miso_s;
        logic        erased;
        logic        enabled;
        logic        lo_seen;
        logic [7:0]  lo_addr;
        logic [7:0]  resp;
        logic        resp_v;
    } isp_prog_st_t;

    isp_prog_st_t s;
    isp_prog_st_t n;
    logic [31:0]  f_data;
    logic         f_valid;
    logic         pop;

    // ==========================================
    // Instruction queue
    isp_fifo #(
        .W     (32),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (CLK_I),
        .rst_i       (RST_I),
        .in_data_i   (CMD_DATA_I),
        .in_valid_i  (CMD_VALID_I),
        .in_ready_o  (CMD_READY_O),
        .out_data_o  (f_data),
        .out_valid_o (f_valid),
        .out_ready_i (pop)
    );

    assign LINK.sck     = s.sck;
    assign LINK.mosi    = s.mosi;
    assign LINK.rst_n   = s.rst_n;
    assign RESP_DATA_O  = s.resp;
    assign RESP_VALID_O = s.resp_v;
    assign SYNC_O       = s.enabled;

    always_comb begin
        logic [7:0] b1;
        logic [7:0] b2;
        logic       skip;
        logic       wtype;
        b1    = f_data[31:24];
        b2    = f_data[23:16];
        skip  = 1'b0;
        wtype = 1'b0;
        pop   = 1'b0;
        n     = s;
        n.miso_s = {s.miso_s[0], LINK.miso};
        n.resp_v = 1'b0;
        case (s.state)
            P_OFF: begin
                n.rst_n   = 1'b1;
                n.sck     = 1'b0;
                n.mosi    = 1'b0;
                n.enabled = 1'b0;
                n.erased  = 1'b0;
                n.lo_seen = 1'b0;
                n.cnt     = '0;
                if (SESSION_I) begin
                    n.state = P_PULSE;
                end
            end
            P_PULSE: begin
                // Clock already low; reset high for a few cycles
                n.sck   = 1'b0;
                n.rst_n = 1'b1;
                n.cnt   = s.cnt + 1'b1;
                if (s.cnt == CW'(RST_PULSE_CYC - 1)) begin
                    n.cnt   = '0;
                    n.rst_n = 1'b0;
                    n.state = P_WAIT;
                end
            end
            P_WAIT: begin
                n.cnt = s.cnt + 1'b1;
                if (s.cnt == CW'(ENABLE_WAIT - 1)) begin
                    n.tx    = ENABLE_WORD;
                    n.mosi  = ENABLE_WORD[31];
                    n.kind  = K_ENABLE;
                    n.bits  = '0;
                    n.ph    = '0;
                    n.state = P_SHIFT;
                end
            end
            P_IDLE: begin
                if (!SESSION_I) begin
                    n.state = P_OFF;
                end else if (f_valid) begin
                    pop   = 1'b1;
                    // Redundant all-ones writes after an erase
                    skip  = s.erased && f_data[7:0] == ERASED_BYTE
                            && (b1 == OP_LD_LO || b1 == OP_LD_HI
                                || b1 == OP_WR_EE);
                    // High byte with no matching low byte first
                    if (b1 == OP_LD_HI
                        && !(s.lo_seen && s.lo_addr == f_data[15:8])) begin
                        skip = 1'b1;
                    end
                    if (b1 == OP_LD_LO) begin
                        n.lo_seen = 1'b1;
                        n.lo_addr = f_data[15:8];
                    end else if (b1 == OP_LD_HI || b1 == OP_WR_PAGE) begin
                        n.lo_seen = 1'b0;
                    end
                    if (b1 == OP_ENABLE && b2 == OP_ERASE) begin
                        n.erased = 1'b1;
                    end
                    wtype = b1 == OP_WR_PAGE || b1 == OP_WR_EE
                            || b1 == OP_WR_EEPG
                            || (b1 == OP_ENABLE && b2 != OP_ECHO);
                    if (skip) begin
                        n.resp   = ERASED_BYTE;
                        n.resp_v = 1'b1;
                    end else begin
                        // Extended address and all words go as given
                        n.tx    = f_data;
                        n.mosi  = f_data[31];
                        n.kind  = K_USER;
                        n.wr    = wtype;
                        n.bits  = '0;
                        n.ph    = '0;
                        n.state = P_SHIFT;
                    end
                end
            end
            P_SHIFT: begin
                // Clock derived from CLK_I, shared with the device
                n.ph = s.ph + 1'b1;
                if (s.ph == 3'(SCK_HALF_CYC - 1)) begin
                    n.sck = 1'b1;
                end else if (s.ph == 3'(2 * SCK_HALF_CYC - 1)) begin
                    // Sample late in high phase, then fall and shift
                    n.ph   = '0;
                    n.sck  = 1'b0;
                    n.rx   = {s.rx[30:0], s.miso_s[1]};
                    n.tx   = {s.tx[30:0], 1'b0};
                    n.mosi = n.tx[31];
                    n.bits = s.bits + 1'b1;
                    if (s.bits == 5'(INSTR_BITS - 1)) begin
                        n.state = P_CHECK;
                    end
                end
            end
            P_CHECK: begin
                n.mosi = 1'b0;
                case (s.kind)
                    K_ENABLE: begin
                        if (s.rx[15:8] == OP_ECHO) begin
                            n.enabled = 1'b1;
                            n.state   = P_IDLE;
                        end else begin
                            n.cnt   = '0;
                            n.state = P_PULSE;
                        end
                    end
                    K_USER: begin
                        n.resp   = s.rx[7:0];
                        n.resp_v = 1'b1;
                        n.state  = P_IDLE;
                        if (s.wr) begin
                            // Poll instead of fixed waits
                            n.tx    = POLL_WORD;
                            n.mosi  = POLL_WORD[31];
                            n.kind  = K_POLL;
                            n.bits  = '0;
                            n.ph    = '0;
                            n.state = P_SHIFT;
                        end
                    end
                    default: begin
                        n.state = P_IDLE;
                        if (s.rx[0]) begin
                            n.tx    = POLL_WORD;
                            n.mosi  = POLL_WORD[31];
                            n.bits  = '0;
                            n.ph    = '0;
                            n.state = P_SHIFT;
                        end
                    end
                endcase
            end
            default: begin
                n.state = P_OFF;
            end
        endcase
    end

    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            s       <= '0;
            s.state <= P_OFF;
            s.rst_n <= 1'b1;
        end else begin
            s <= n;
        end
    end
endmodule
`default_nettype wire

// ==== dv/isp_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module isp_props (
    input wire logic CLK_I,       // Clock
    input wire logic RST_I,       // Reset
    input wire logic sck,         // Serial clock
    input wire logic mosi,        // Data to device
    input wire logic miso,        // Data from device
    input wire logic rst_n,       // Reset pin
    input wire logic PROG_MODE_O, // Enabled
    input wire logic BUSY_O       // Self-timed write
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // ========
    // Clock phases
    sequence low_phase;
        !sck [*3];
    endsequence
    sequence high_phase;
        sck [*3];
    endsequence
    AST_SCK_LOW: assert property ($fell(sck) |-> low_phase)
        else $error("serial clock low phase too short");
    AST_SCK_HIGH: assert property ($rose(sck) |-> high_phase)
        else $error("serial clock high phase too short");
    AST_MOSI_HOLD: assert property ($rose(sck) |-> $stable(mosi) [*3])
        else $error("data in moved near rising clock");
    AST_MISO_FALL: assert property ($changed(miso) |-> !sck)
        else $error("data out moved while clock high");
    AST_IDLE_CLK: assert property (rst_n |-> !sck)
        else $error("serial clock runs with reset pin high");
    AST_PULSE_LEN: assert property ($rose(rst_n) |-> rst_n [*2])
        else $error("reset pulse too short");
    AST_PULSE_CLK: assert property ($rose(rst_n) |-> !$past(sck))
        else $error("reset pulsed with clock high");
    AST_MODE_DROP: assert property (rst_n [*4] |-> !PROG_MODE_O)
        else $error("programming mode kept with reset pin high");
    AST_BUSY_MODE: assert property ($rose(BUSY_O) |-> PROG_MODE_O)
        else $error("write started without enable");
    AST_BUSY_END: assert property (BUSY_O |-> ##[0:200] !BUSY_O)
        else $error("busy never ends");
endmodule
`default_nettype wire

// ==== dv/isp_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    import isp_pkg::*;
    logic        CLK_I       = 1'b0;
    logic        RST_I       = 1'b1;
    logic        SESSION_I   = 1'b0;
    logic [31:0] CMD_DATA_I  = 32'h0000_0000;
    logic        CMD_VALID_I = 1'b0;
    logic        CMD_READY_O, RESP_VALID_O, SYNC_O, PROG_MODE_O, BUSY_O;
    logic [7:0]  RESP_DATA_O;
    int          err_count   = 0;
    int          num_checks  = 0;
    int          cyc         = 0;
    isp_if lnk();
    isp_prog #(.ENABLE_WAIT(50)) isp_prog_i (.CLK_I(CLK_I), .RST_I(RST_I),
        .LINK(lnk.prog), .SESSION_I(SESSION_I), .CMD_DATA_I(CMD_DATA_I),
        .CMD_VALID_I(CMD_VALID_I), .CMD_READY_O(CMD_READY_O),
        .RESP_DATA_O(RESP_DATA_O), .RESP_VALID_O(RESP_VALID_O),
        .SYNC_O(SYNC_O));
    isp_dev #(.FLASH_WAIT_CYC(30), .EE_WAIT_CYC(30), .ERASE_WAIT_CYC(40))
        isp_dev_i (.CLK_I(CLK_I), .RST_I(RST_I), .LINK(lnk.dev),
        .PROG_MODE_O(PROG_MODE_O), .BUSY_O(BUSY_O));
    isp_props isp_props_i (.CLK_I(CLK_I), .RST_I(RST_I), .sck(lnk.sck),
        .mosi(lnk.mosi), .miso(lnk.miso), .rst_n(lnk.rst_n),
        .PROG_MODE_O(PROG_MODE_O), .BUSY_O(BUSY_O));
    initial begin
        forever #50 CLK_I = ~CLK_I;
    end
    always @(posedge CLK_I) begin
        cyc++;
        if (cyc == 80000) begin
            err_count++;
            summarize();
        end
    end
    // ========
    // Access tasks
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: byte %h not %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected at %0t: flag %b not %b", $time, g, e);
        end
    endtask
    task automatic push(input logic [31:0] w);
        @(posedge CLK_I);
        #1 CMD_DATA_I = w;
        CMD_VALID_I = 1'b1;
        while (CMD_READY_O !== 1'b1) begin
            @(posedge CLK_I);
            #1;
        end
        @(posedge CLK_I);
        #1 CMD_VALID_I = 1'b0;
    endtask
    task automatic getr(input logic [7:0] e, input bit c);
        int n;
        n = 0;
        do begin
            @(posedge CLK_I);
            #1 n++;
        end while (RESP_VALID_O !== 1'b1 && n < 20000);
        if (n >= 20000) begin
            err_count++;
            $display("unexpected at %0t: no reply", $time);
        end else if (c) begin
            chk8(RESP_DATA_O, e);
        end
    endtask
    task automatic run(input logic [31:0] w, input logic [7:0] e, input bit c);
        push(w);
        getr(e, c);
    endtask
    // ========
    // Tests
    initial begin
        repeat (16) @(posedge CLK_I);
        #1 RST_I = 1'b0;
        chk1(lnk.rst_n, 1'b1);
        for (int a = 0; a < 16; a++)
            push({OP_RD_EE, 8'h00, 8'(a), 8'h00});
        chk1(CMD_READY_O, 1'b0);
        SESSION_I = 1'b1;
        for (int a = 0; a < 16; a++)
            getr(ERASED_BYTE, 1);
        chk1(SYNC_O, 1'b1);
        chk1(PROG_MODE_O, 1'b1);
        run({OP_LD_EXT, 24'h00_0000}, 8'h00, 0);
        run({OP_LD_LO, 24'h00_0512}, 8'h00, 0);
        run({OP_LD_HI, 24'h00_0534}, 8'h00, 0);
        run({OP_LD_HI, 24'h00_0656}, ERASED_BYTE, 1);
        run({OP_WR_PAGE, 24'h00_0000}, 8'h00, 0);
        run({OP_RD_LO, 24'h00_0500}, 8'h12, 1);
        run({OP_RD_HI, 24'h00_0500}, 8'h34, 1);
        run({OP_RD_HI, 24'h00_0600}, ERASED_BYTE, 1);
        run({OP_WR_EE, 24'h00_10A5}, 8'h00, 0);
        chk1(BUSY_O, 1'b1);
        run({OP_RD_EE, 24'h00_1000}, 8'hA5, 1);
        chk1(BUSY_O, 1'b0);
        run({OP_WR_EE, 24'h00_105A}, 8'h00, 0);
        run({OP_RD_EE, 24'h00_1000}, 8'h5A, 1);
        SESSION_I = 1'b0;
        repeat (20) @(posedge CLK_I);
        #1 chk1(lnk.rst_n, 1'b1);
        chk1(PROG_MODE_O, 1'b0);
        SESSION_I = 1'b1;
        run({OP_RD_EE, 24'h00_1000}, 8'h5A, 1);
        run({OP_ENABLE, OP_ERASE, 16'h0000}, 8'h00, 0);
        chk1(BUSY_O, 1'b1);
        run({OP_RD_LO, 24'h00_0500}, ERASED_BYTE, 1);
        run({OP_RD_EE, 24'h00_1000}, ERASED_BYTE, 1);
        summarize();
    end
endmodule
`default_nettype wire
